/* cdmm_params.svh */
`ifndef CDMM_PARAMS_SVH
`define CDMM_PARAMS_SVH
`define CDMM_TEXT_DEPTH   80
`define CDMM_GLYPH_DEPTH  128
`define CDMM_LINE1_END    7'h4F
`define CDMM_LINE_A_END   7'h27
`define CDMM_LINE_B_START 7'h40
`define CDMM_LINE_B_END   7'h67
`define CDMM_LINE_B_OFF   7'h18
`define CDMM_VIS_CHARS    7'h20
`define CDMM_VIS_HALF     7'h10
`define CDMM_CURSOR_ROW   3'h7
`define CDMM_BLANK_CODE   8'h20
`endif

/* cdmm_pkg.sv */
package cdmm_pkg;
    typedef enum logic [1:0] {
        CDMM_MODE_1X32 = 2'h0,
        CDMM_MODE_2X16 = 2'h1,
        CDMM_MODE_1X16 = 2'h3
    } cdmm_mode_t;
    typedef enum logic [1:0] {
        CDMM_CMD_NONE     = 2'h0,
        CDMM_CMD_SET_TEXT = 2'h1,
        CDMM_CMD_SET_GLY  = 2'h3,
        CDMM_CMD_XFER     = 2'h2
    } cdmm_cmd_t;
endpackage : cdmm_pkg

/* cdmm_ram.sv */
`timescale 1ns/10ps
module cdmm_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 80,
    parameter int AW    = 7
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];
    // Out-of-range writes are dropped so the array never aliases
    always_ff @(posedge clk) begin
        if (we && (32'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
        rdata <= (32'(raddr) < DEPTH) ? mem[raddr] : '0;
    end
endmodule : cdmm_ram

/* cdmm_char_display_memory_map.sv */
`timescale 1ns/10ps
`include "cdmm_params.svh"
module cdmm_char_display_memory_map (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire cdmm_pkg::cdmm_mode_t line_mode,
    input  wire logic                entry_up,
    input  wire cdmm_pkg::cdmm_cmd_t cmd,
    input  wire logic                sel_glyph,
    input  wire logic                xfer_write,
    input  wire logic [6:0]          cmd_addr,
    input  wire logic [7:0]          wr_data,
    input  wire logic                shift_en,
    input  wire logic                shift_right,
    input  wire logic                cursor_on,
    input  wire logic [4:0]          disp_col,
    input  wire logic                disp_line,
    input  wire logic [2:0]          disp_row,
    input  wire logic [7:0]          rom_row_data,
    output logic      [7:0]          rom_code,
    output logic      [2:0]          rom_row,
    output logic      [7:0]          rd_data,
    output logic                     rd_valid,
    output logic      [6:0]          busy_counter_read,
    output logic      [4:0]          pixel_row,
    output logic                     pixel_valid
);
    import cdmm_pkg::*;

    logic [6:0] addr_q;
    logic [6:0] addr_d;
    logic       glyph_sel_q;
    logic [6:0] shift_q;
    logic [6:0] shift_d;
    logic       rd_pend_q;
    logic       rd_glyph_q;
    logic [7:0] text_rdata;
    logic [7:0] text_disp_rdata;
    logic [7:0] glyph_rdata;
    logic [7:0] glyph_disp_rdata;

    // Line bounds by mode
    wire is_two   = (line_mode == CDMM_MODE_2X16);
    wire is_1x32  = (line_mode == CDMM_MODE_1X32);
    wire [6:0] first_end = is_1x32 ? `CDMM_LINE1_END : `CDMM_LINE_A_END;

    // Access stepping: text address wraps across lines, glyph address steps by one with no line wrap
    wire [6:0] inc_t =
        (is_two && addr_q == `CDMM_LINE_A_END) ? `CDMM_LINE_B_START :
        (is_two && addr_q == `CDMM_LINE_B_END) ? 7'h00 :
        (!is_two && addr_q == first_end)       ? 7'h00 :
        7'(addr_q + 7'h01);
    wire [6:0] dec_t =
        (is_two && addr_q == `CDMM_LINE_B_START) ? `CDMM_LINE_A_END :
        (addr_q == 7'h00) ? (is_two ? `CDMM_LINE_B_END : first_end) :
        7'(addr_q - 7'h01);
    wire [6:0] step_g = entry_up ? 7'(addr_q + 7'h01) : 7'(addr_q - 7'h01);
    wire [6:0] step_t = entry_up ? inc_t : dec_t;
    wire       xfer   = (cmd == CDMM_CMD_XFER);

    // Text address must be legal for the mode before loading
    wire text_ok = is_two ? ((cmd_addr <= `CDMM_LINE_A_END) ||
                             ((cmd_addr >= `CDMM_LINE_B_START) &&
                              (cmd_addr <= `CDMM_LINE_B_END)))
                          : (cmd_addr <= first_end);

    always_comb begin
        addr_d = addr_q;
        if (cmd == CDMM_CMD_SET_TEXT && text_ok) begin
            addr_d = cmd_addr;
        end else if (cmd == CDMM_CMD_SET_GLY) begin
            addr_d = {addr_q[6], cmd_addr[5:0]};
        end else if (xfer) begin
            addr_d = glyph_sel_q ? step_g : step_t;
        end
    end

    // Display shift: one offset, each line wraps within its own span
    wire [6:0] span = is_two ? 7'(`CDMM_LINE_A_END + 7'h01) : 7'(first_end + 7'h01);
    always_comb begin
        shift_d = shift_q;
        if (shift_en) begin
            if (shift_right) begin
                shift_d = (shift_q == 7'h00) ? 7'(span - 7'h01) : 7'(shift_q - 7'h01);
            end else begin
                shift_d = (shift_q == 7'(span - 7'h01)) ? 7'h00 : 7'(shift_q + 7'h01);
            end
        end
    end

    // Visible text position to address
    wire [6:0] col_in  = {2'b00, disp_col};
    wire [6:0] vis_lim = is_1x32 ? `CDMM_VIS_CHARS : `CDMM_VIS_HALF;
    wire       col_ok  = col_in < vis_lim;
    wire [7:0] pos_raw = 8'(col_in) + 8'(shift_q);
    wire [6:0] pos_w   = (pos_raw >= 8'(span)) ? 7'(pos_raw - 8'(span)) : pos_raw[6:0];
    wire       use_b   = is_two && disp_line;
    wire [6:0] disp_addr = use_b ? 7'(pos_w + `CDMM_LINE_B_START) : pos_w;
    // Text RAM is packed: line B sits directly after line A in storage
    // Packing applies only in two-line mode; one-line 32 uses 00h to 4Fh directly
    wire       pack_b   = is_two && (addr_q >= `CDMM_LINE_B_START);
    wire [6:0] to_idx_a = pack_b ? 7'(addr_q - `CDMM_LINE_B_OFF) : addr_q;
    wire [6:0] to_idx_d = use_b ? 7'(pos_w + `CDMM_LINE_A_END + 7'h01) : pos_w;
    wire [6:0] glyph_a  = addr_q;
    wire       wr_text  = xfer && xfer_write && !glyph_sel_q;
    wire       wr_glyph = xfer && xfer_write && glyph_sel_q;

    // Access port: any stored location, shown or not
    cdmm_ram #(.WIDTH(8), .DEPTH(`CDMM_TEXT_DEPTH), .AW(7)) u_text_ram (
        .clk   (clk),
        .we    (wr_text),
        .waddr (to_idx_a),
        .wdata (wr_data),
        .raddr (to_idx_a),
        .rdata (text_rdata)
    );
    cdmm_ram #(.WIDTH(8), .DEPTH(`CDMM_TEXT_DEPTH), .AW(7)) u_text_view (
        .clk   (clk),
        .we    (wr_text),
        .waddr (to_idx_a),
        .wdata (wr_data),
        .raddr (to_idx_d),
        .rdata (text_disp_rdata)
    );
    cdmm_ram #(.WIDTH(8), .DEPTH(`CDMM_GLYPH_DEPTH), .AW(7)) u_user_glyph_ram (
        .clk   (clk),
        .we    (wr_glyph),
        .waddr (glyph_a),
        .wdata ({3'b000, wr_data[4:0]}),
        .raddr (glyph_a),
        .rdata (glyph_rdata)
    );

    // Display pipeline stage 1: code fetched, row and cursor hit held
    logic [2:0] row_p_q;
    logic       cur_p_q;
    logic       vis_p_q;
    logic [2:0] row_p2_q;
    logic       cur_p2_q;
    logic       vis_p2_q;
    logic       user_p2_q;
    wire        cur_hit = cursor_on && (disp_addr == addr_q);
    wire        is_user = (text_disp_rdata[7:4] == 4'h0);
    wire [6:0]  glyph_d = {text_disp_rdata[3:0], row_p_q};
    cdmm_ram #(.WIDTH(8), .DEPTH(`CDMM_GLYPH_DEPTH), .AW(7)) u_glyph_view (
        .clk   (clk),
        .we    (wr_glyph),
        .waddr (glyph_a),
        .wdata ({3'b000, wr_data[4:0]}),
        .raddr (glyph_d),
        .rdata (glyph_disp_rdata)
    );

    // Glyph ROM row comes back in the cycle after rom_code
    wire [4:0] glyph_bits = user_p2_q ? glyph_disp_rdata[4:0] : rom_row_data[4:0];
    wire       curs_row   = cur_p2_q && (row_p2_q == `CDMM_CURSOR_ROW);
    wire [4:0] pix_d      = glyph_bits | {5{curs_row}};

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q      <= 7'h00;
            glyph_sel_q <= 1'b0;
            shift_q     <= 7'h00;
            rd_pend_q   <= 1'b0;
            rd_glyph_q  <= 1'b0;
        end else begin
            addr_q      <= addr_d;
            shift_q     <= shift_d;
            rd_pend_q   <= xfer && !xfer_write;
            rd_glyph_q  <= glyph_sel_q;
            if (cmd == CDMM_CMD_SET_TEXT && text_ok) begin
                glyph_sel_q <= 1'b0;
            end else if (cmd == CDMM_CMD_SET_GLY) begin
                glyph_sel_q <= 1'b1;
            end else if (xfer) begin
                glyph_sel_q <= sel_glyph ? 1'b1 : glyph_sel_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            row_p_q   <= 3'h0;
            cur_p_q   <= 1'b0;
            vis_p_q   <= 1'b0;
            row_p2_q  <= 3'h0;
            cur_p2_q  <= 1'b0;
            vis_p2_q  <= 1'b0;
            user_p2_q <= 1'b0;
        end else begin
            row_p_q   <= disp_row;
            cur_p_q   <= cur_hit;
            vis_p_q   <= col_ok && !(disp_line && !is_two);
            row_p2_q  <= row_p_q;
            cur_p2_q  <= cur_p_q;
            vis_p2_q  <= vis_p_q;
            user_p2_q <= is_user;
        end
    end

    // Outputs all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            rom_code          <= `CDMM_BLANK_CODE;
            rom_row           <= 3'h0;
            rd_data           <= 8'h00;
            rd_valid          <= 1'b0;
            busy_counter_read <= 7'h00;
            pixel_row         <= 5'h00;
            pixel_valid       <= 1'b0;
        end else begin
            rom_code          <= text_disp_rdata;
            rom_row           <= row_p_q;
            if (rd_pend_q) begin
                rd_data <= rd_glyph_q ? glyph_rdata : text_rdata;
            end
            rd_valid          <= rd_pend_q;
            busy_counter_read <= addr_q;
            pixel_row         <= vis_p2_q ? pix_d : 5'h00;
            pixel_valid       <= vis_p2_q;
        end
    end
endmodule : cdmm_char_display_memory_map

/* cdmm_rom_model.sv */
`timescale 1ns/10ps
module cdmm_rom_model (
    input  wire logic       clk,
    input  wire logic [7:0] rom_code,
    input  wire logic [2:0] rom_row,
    output logic      [7:0] rom_row_data
);
    // Pattern depends on code and row, so a wrong lookup shows at the pixels
    always_ff @(posedge clk) begin
        rom_row_data <= {3'h0, rom_code[4:0] ^ {2'h0, rom_row}};
    end
endmodule : cdmm_rom_model

/* cdmm_char_display_memory_map_assertions.sv */
`timescale 1ns/10ps
module cdmm_char_display_memory_map_assertions
    import cdmm_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire cdmm_mode_t line_mode,
    input wire logic       entry_up,
    input wire cdmm_cmd_t  cmd,
    input wire logic       xfer_write,
    input wire logic [6:0] cmd_addr,
    input wire logic [4:0] disp_col,
    input wire logic       disp_line,
    input wire logic [2:0] disp_row,
    input wire logic [2:0] rom_row,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic [6:0] busy_counter_read,
    input wire logic [4:0] pixel_row,
    input wire logic       pixel_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_answer_late: assert property (cmd == CDMM_CMD_XFER && !xfer_write |-> ##2 rd_valid)
        else $error("read answer missing");
    a_read_answer_cause: assert property (rd_valid |-> $past(cmd, 2) == CDMM_CMD_XFER && !$past(xfer_write, 2))
        else $error("read answer without read");
    a_glyph_set_low: assert property (cmd == CDMM_CMD_SET_GLY |-> ##2 busy_counter_read[5:0] == $past(cmd_addr[5:0], 2))
        else $error("glyph address not loaded");
    a_text_set_load: assert property (cmd == CDMM_CMD_SET_TEXT && line_mode == CDMM_MODE_1X32 && cmd_addr <= 7'h4F
        |-> ##2 busy_counter_read == $past(cmd_addr, 2))
        else $error("text address not loaded");
    a_counter_step_up: assert property ((cmd == CDMM_CMD_XFER && $past(cmd) == CDMM_CMD_NONE && entry_up
        && line_mode == CDMM_MODE_1X32) ##1 (busy_counter_read < 7'h4F)
        |=> busy_counter_read == $past(busy_counter_read) + 7'h1)
        else $error("counter did not step");
    a_pixel_off_zero: assert property (!pixel_valid |-> pixel_row == 5'h00)
        else $error("pixels lit off screen");
    a_rom_row_follow: assert property (!disp_line && disp_col < 5'h10 |-> ##2 rom_row == $past(disp_row, 2))
        else $error("glyph row not passed on");
    a_rd_data_stands: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data changed");
endmodule : cdmm_char_display_memory_map_assertions
bind cdmm_char_display_memory_map cdmm_char_display_memory_map_assertions i_chk (.*);

/* cdmm_char_display_memory_map_tb_top.sv */
`timescale 1ns/10ps
module cdmm_char_display_memory_map_tb_top;
    import cdmm_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    cdmm_mode_t line_mode = CDMM_MODE_1X32;
    logic       entry_up = 1'b1;
    cdmm_cmd_t  cmd = CDMM_CMD_NONE;
    logic       xfer_write = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] wr_data = 8'h00;
    logic       shift_en = 1'b0;
    logic       shift_right = 1'b0;
    logic       cursor_on = 1'b0;
    logic [4:0] disp_col = 5'h00;
    logic [2:0] disp_row = 3'h0;
    logic       disp_line = 1'b0;
    logic [7:0] rom_row_data, rom_code, rd_data;
    logic [2:0] rom_row;
    logic [6:0] busy_counter_read;
    logic [4:0] pixel_row;
    logic       rd_valid, pixel_valid;
    int         bad_count = 0;
    int         comparisons = 0;
    cdmm_char_display_memory_map i_dut (.clk(clk), .rst(rst), .line_mode(line_mode),
        .entry_up(entry_up), .cmd(cmd), .sel_glyph(1'b0), .xfer_write(xfer_write),
        .cmd_addr(cmd_addr), .wr_data(wr_data), .shift_en(shift_en), .shift_right(shift_right),
        .cursor_on(cursor_on), .disp_col(disp_col), .disp_line(disp_line), .disp_row(disp_row),
        .rom_row_data(rom_row_data), .rom_code(rom_code), .rom_row(rom_row), .rd_data(rd_data),
        .rd_valid(rd_valid), .busy_counter_read(busy_counter_read), .pixel_row(pixel_row),
        .pixel_valid(pixel_valid));
    cdmm_rom_model i_rom (.clk(clk), .rom_code(rom_code), .rom_row(rom_row),
        .rom_row_data(rom_row_data));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic note(input logic ok, input string what);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : note
    task automatic chk_cnt(input logic [6:0] exp);
        note(busy_counter_read === exp, "counter value");
    endtask : chk_cnt
    task automatic chk_byte(input logic [7:0] exp);
        note(rd_data === exp, "read data");
    endtask : chk_byte
    // Waits well past the two-cycle answer so counter and read data have settled
    task automatic req(input cdmm_cmd_t c, input logic [6:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        cmd <= c;
        cmd_addr <= a;
        xfer_write <= w;
        wr_data <= d;
        @(posedge clk);
        cmd <= CDMM_CMD_NONE;
        repeat (3) @(posedge clk);
        #1;
    endtask : req
    task automatic scan(input logic [4:0] col, input logic [2:0] row, input logic [4:0] exp);
        @(posedge clk);
        disp_col <= col;
        disp_row <= row;
        repeat (5) @(posedge clk);
        #1;
        note(pixel_row === exp && pixel_valid === 1'b1, "pixel row");
    endtask : scan
    task automatic shift(input logic right);
        @(posedge clk);
        shift_right <= right;
        shift_en <= 1'b1;
        @(posedge clk);
        shift_en <= 1'b0;
    endtask : shift
    task automatic sc_wide_line;
        req(CDMM_CMD_SET_TEXT, 7'h4F, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'hA5);
        chk_cnt(7'h00);
        req(CDMM_CMD_SET_TEXT, 7'h4F, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b0, 8'h00);
        chk_byte(8'hA5);
    endtask : sc_wide_line
    task automatic sc_two_lines;
        line_mode <= CDMM_MODE_2X16;
        req(CDMM_CMD_SET_TEXT, 7'h27, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'h3C);
        chk_cnt(7'h40);
        req(CDMM_CMD_SET_TEXT, 7'h30, 1'b0, 8'h00);
        chk_cnt(7'h40);
        req(CDMM_CMD_SET_TEXT, 7'h67, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'hA5);
        chk_cnt(7'h00);
        req(CDMM_CMD_SET_TEXT, 7'h27, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b0, 8'h00);
        chk_byte(8'h3C);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'h43);
        disp_line <= 1'b1;
        scan(5'h00, 3'h1, 5'h02);
        disp_line <= 1'b0;
        line_mode <= CDMM_MODE_1X32;
        entry_up <= 1'b0;
        req(CDMM_CMD_SET_TEXT, 7'h10, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'h77);
        chk_cnt(7'h0F);
        entry_up <= 1'b1;
    endtask : sc_two_lines
    task automatic sc_glyphs;
        req(CDMM_CMD_SET_GLY, 7'h3F, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'h00);
        chk_cnt(7'h40);
        req(CDMM_CMD_SET_GLY, 7'h0A, 1'b0, 8'h00);
        chk_cnt(7'h4A);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'h15);
        req(CDMM_CMD_SET_TEXT, 7'h00, 1'b0, 8'h00);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'h09);
        req(CDMM_CMD_XFER, 7'h00, 1'b1, 8'h41);
        req(CDMM_CMD_SET_TEXT, 7'h01, 1'b0, 8'h00);
        cursor_on <= 1'b1;
        scan(5'h00, 3'h2, 5'h15);
        scan(5'h01, 3'h3, 5'h02);
        scan(5'h01, 3'h7, 5'h1F);
        cursor_on <= 1'b0;
        // Shifting right by one brings the last location into the first column
        shift(1'b1);
        scan(5'h00, 3'h0, 5'h05);
        shift(1'b0);
    endtask : sc_glyphs
    task automatic print_verdict;
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        sc_wide_line();
        sc_two_lines();
        sc_glyphs();
        print_verdict();
    end
endmodule : cdmm_char_display_memory_map_tb_top
